// ==== logic/ccr_pkg.sv ====
// Package for the channel one configuration and calibration register bank.
// Assumes a 16-bit register port with word addresses as printed.
package ccr_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam logic [5:0] ADDR_SETUP = 6'h0E;
	localparam logic [5:0] ADDR_OCAL_HI = 6'h0F;
	localparam logic [5:0] ADDR_OCAL_LO = 6'h10;
	localparam logic [5:0] ADDR_GCAL_HI = 6'h11;
	localparam logic [5:0] ADDR_GCAL_LO = 6'h12;
	localparam logic [5:0] ADDR_DC_COEFF = 6'h13;
	localparam logic [15:0] SETUP_RESET = 16'h0000;
	localparam logic [15:0] OCAL_HI_RESET = 16'h0000;
	localparam logic [7:0] OCAL_LO_RESET = 8'h00;
	localparam logic [15:0] GCAL_HI_RESET = 16'h8000;
	localparam logic [7:0] GCAL_LO_RESET = 8'h00;
	localparam logic [3:0] DC_COEFF_RESET = 4'h0;
	localparam logic [3:0] DC_COEFF_OFF = 4'h0;
	localparam int PHASE_MSB = 15;
	localparam int PHASE_LSB = 6;
	localparam int FILT_OFF_BIT = 2;
	localparam int SEL_MSB = 1;
	localparam int LO_MSB = 15;
	localparam int LO_LSB = 8;
	localparam logic [15:0] SETUP_WMASK = 16'hFFC7;
	localparam logic [15:0] READ_UNMAPPED = 16'h0000;
	typedef enum logic [1:0] {
		CCR_SEL_PINS,
		CCR_SEL_SHORT,
		CCR_SEL_TEST_POS,
		CCR_SEL_TEST_NEG
	} ccr_sel_e;
endpackage

// ==== logic/ccr_input_route.sv ====
// Input routing decode for the channel.
// Assumes the selector comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ccr_input_route (
	input wire logic [1:0] sel,
	output logic route_pins,
	output logic route_short,
	output logic route_test_pos,
	output logic route_test_neg
);
	assign route_pins = (sel == 2'(ccr_pkg::CCR_SEL_PINS)); // RULE3
	assign route_short = (sel == 2'(ccr_pkg::CCR_SEL_SHORT)); // RULE4
	assign route_test_pos = (sel == 2'(ccr_pkg::CCR_SEL_TEST_POS)); // RULE5
	assign route_test_neg = (sel == 2'(ccr_pkg::CCR_SEL_TEST_NEG)); // RULE5
endmodule
`default_nettype wire

// ==== logic/ccr_regs.sv ====
// Channel one configuration and calibration register bank.
// Assumes a single-cycle strobe master on the same clock; no waits.
// How it works
// RULE1: Setup bits 15:6 hold signed phase delay, read/write, reset zero.
// RULE2: Setup bit 2 set forces this channel's DC filter off.
// RULE3: Selector 00 routes the channel's own input pins.
// RULE4: Selector 01 shorts converter inputs together.
// RULE5: Selector 10 feeds positive test signal, 11 negative.
// RULE6: High offset register holds offset word bits 23:8.
// RULE7: Low offset register upper byte holds offset word bits 7:0.
// RULE8: Lower byte of both low calibration registers reads zero.
// RULE9: High gain register holds gain bits 23:8, resets to 8000h.
// RULE10: Low gain upper byte holds gain bits 7:0, resets zero.
// RULE11: Calibration registers decode at Fh, 10h, 11h, 12h; offsets reset zero.
// RULE12: Setup bits 5:3 always read zero.
// RULE13: Global coefficient code zero disables filter; others pick coefficient.
// RULE14: Setup register decodes at Eh and resets to 0000h.
// RULE15: Writes to reserved bits are ignored.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ccr_regs (
	input wire logic clock,
	input wire logic srst,
	input wire logic [5:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [15:0] rdata,
	output logic [9:0] ch1_phase_delay,
	output logic ch1_filter_active,
	output logic [3:0] ch1_filter_coeff,
	output logic [1:0] ch1_input_select,
	output logic ch1_route_pins,
	output logic ch1_route_short,
	output logic ch1_route_test_pos,
	output logic ch1_route_test_neg,
	output logic [23:0] ch1_offset_word,
	output logic [23:0] ch1_gain_word
);
	// ==========================================
	// Address decode
	// ==========================================
	function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
		hit = (a == target);
	endfunction

	wire logic sel_setup = hit(addr, ccr_pkg::ADDR_SETUP); // RULE14
	wire logic sel_ocal_hi = hit(addr, ccr_pkg::ADDR_OCAL_HI); // RULE11
	wire logic sel_ocal_lo = hit(addr, ccr_pkg::ADDR_OCAL_LO); // RULE11
	wire logic sel_gcal_hi = hit(addr, ccr_pkg::ADDR_GCAL_HI); // RULE11
	wire logic sel_gcal_lo = hit(addr, ccr_pkg::ADDR_GCAL_LO); // RULE11
	wire logic sel_coeff = hit(addr, ccr_pkg::ADDR_DC_COEFF);
	wire logic sel_any = sel_setup || sel_ocal_hi || sel_ocal_lo ||
		sel_gcal_hi || sel_gcal_lo || sel_coeff;

	// ==========================================
	// Storage
	// ==========================================
	logic [15:0] setup_reg;
	logic [15:0] ocal_hi_reg;
	logic [7:0] ocal_lo_reg;
	logic [15:0] gcal_hi_reg;
	logic [7:0] gcal_lo_reg;
	logic [3:0] coeff_reg;
	logic [15:0] rdata_reg;

	// Reserved setup bits are masked on write so they stay zero.
	wire logic [15:0] setup_next = wdata & ccr_pkg::SETUP_WMASK; // RULE15 RULE12

	always_ff @(posedge clock) begin
		if (srst) begin
			setup_reg <= ccr_pkg::SETUP_RESET; // RULE14 RULE1
			ocal_hi_reg <= ccr_pkg::OCAL_HI_RESET; // RULE11
			ocal_lo_reg <= ccr_pkg::OCAL_LO_RESET; // RULE11
			gcal_hi_reg <= ccr_pkg::GCAL_HI_RESET; // RULE9
			gcal_lo_reg <= ccr_pkg::GCAL_LO_RESET; // RULE10
			coeff_reg <= ccr_pkg::DC_COEFF_RESET;
		end else if (wr_stb) begin
			if (sel_setup) setup_reg <= setup_next; // RULE1 RULE2
			if (sel_ocal_hi) ocal_hi_reg <= wdata; // RULE6
			if (sel_ocal_lo) ocal_lo_reg <= wdata[ccr_pkg::LO_MSB:ccr_pkg::LO_LSB]; // RULE7
			if (sel_gcal_hi) gcal_hi_reg <= wdata; // RULE9
			if (sel_gcal_lo) gcal_lo_reg <= wdata[ccr_pkg::LO_MSB:ccr_pkg::LO_LSB]; // RULE10
			if (sel_coeff) coeff_reg <= wdata[3:0];
		end
	end

	// ==========================================
	// Read path
	// ==========================================
	wire logic [15:0] rd_mux =
		sel_setup ? setup_reg :
		sel_ocal_hi ? ocal_hi_reg :
		sel_ocal_lo ? {ocal_lo_reg, 8'h00} : // RULE8
		sel_gcal_hi ? gcal_hi_reg :
		sel_gcal_lo ? {gcal_lo_reg, 8'h00} : // RULE8
		sel_coeff ? {12'h000, coeff_reg} :
		ccr_pkg::READ_UNMAPPED;

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_reg <= 16'h0000;
		end else if (rd_stb) begin
			rdata_reg <= rd_mux;
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign rdata = rdata_reg;

	// ==========================================
	// Control outputs
	// ==========================================
	logic route_pins_w;
	logic route_short_w;
	logic route_pos_w;
	logic route_neg_w;

	ccr_input_route u_route (
		.sel(setup_reg[ccr_pkg::SEL_MSB:0]),
		.route_pins(route_pins_w),
		.route_short(route_short_w),
		.route_test_pos(route_pos_w),
		.route_test_neg(route_neg_w)
	);

	wire logic filter_on_w = !setup_reg[ccr_pkg::FILT_OFF_BIT] && // RULE2
		(coeff_reg != ccr_pkg::DC_COEFF_OFF); // RULE13

	logic filter_active_reg;
	logic route_pins_reg;
	logic route_short_reg;
	logic route_pos_reg;
	logic route_neg_reg;

	always_ff @(posedge clock) begin
		if (srst) begin
			filter_active_reg <= 1'b0;
			route_pins_reg <= 1'b1;
			route_short_reg <= 1'b0;
			route_pos_reg <= 1'b0;
			route_neg_reg <= 1'b0;
		end else begin
			filter_active_reg <= filter_on_w; // RULE2 RULE13
			route_pins_reg <= route_pins_w; // RULE3
			route_short_reg <= route_short_w; // RULE4
			route_pos_reg <= route_pos_w; // RULE5
			route_neg_reg <= route_neg_w; // RULE5
		end
	end

	assign ch1_phase_delay = setup_reg[ccr_pkg::PHASE_MSB:ccr_pkg::PHASE_LSB]; // RULE1
	assign ch1_input_select = setup_reg[ccr_pkg::SEL_MSB:0];
	assign ch1_filter_active = filter_active_reg;
	assign ch1_filter_coeff = coeff_reg;
	assign ch1_route_pins = route_pins_reg;
	assign ch1_route_short = route_short_reg;
	assign ch1_route_test_pos = route_pos_reg;
	assign ch1_route_test_neg = route_neg_reg;
	assign ch1_offset_word = {ocal_hi_reg, ocal_lo_reg}; // RULE6 RULE7
	assign ch1_gain_word = {gcal_hi_reg, gcal_lo_reg}; // RULE9 RULE10

	// ==========================================
	// Checks
	// ==========================================
	phase_write_a: assert property (@(posedge clock) disable iff (srst) // RULE1
		wr_stb && sel_setup |=> ch1_phase_delay == $past(wdata[15:6]))
		else $error("phase delay not written");
	filter_off_a: assert property (@(posedge clock) disable iff (srst) // RULE2
		setup_reg[2] |=> !ch1_filter_active)
		else $error("filter active while channel override set");
	route_pins_a: assert property (@(posedge clock) disable iff (srst) // RULE3
		setup_reg[1:0] == 2'b00 |=> ch1_route_pins && !ch1_route_short)
		else $error("pins not routed");
	route_short_a: assert property (@(posedge clock) disable iff (srst) // RULE4
		setup_reg[1:0] == 2'b01 |=> ch1_route_short && !ch1_route_pins)
		else $error("inputs not shorted");
	route_test_a: assert property (@(posedge clock) disable iff (srst) // RULE5
		setup_reg[1] |=> (ch1_route_test_pos != ch1_route_test_neg))
		else $error("test signal routing wrong");
	ocal_write_a: assert property (@(posedge clock) disable iff (srst) // RULE6
		wr_stb && sel_ocal_hi |=> ch1_offset_word[23:8] == $past(wdata))
		else $error("offset high not written");
	ocal_lo_a: assert property (@(posedge clock) disable iff (srst) // RULE7
		wr_stb && sel_ocal_lo |=> ch1_offset_word[7:0] == $past(wdata[15:8]))
		else $error("offset low not written");
	lo_reserved_a: assert property (@(posedge clock) disable iff (srst) // RULE8
		rd_stb && (sel_ocal_lo || sel_gcal_lo) |=> rdata[7:0] == 8'h00)
		else $error("reserved low byte not zero");
	gain_reset_a: assert property (@(posedge clock) // RULE9
		srst |=> ch1_gain_word == 24'h800000)
		else $error("gain reset value wrong");
	gcal_lo_a: assert property (@(posedge clock) disable iff (srst) // RULE10
		wr_stb && sel_gcal_lo |=> ch1_gain_word[7:0] == $past(wdata[15:8]))
		else $error("gain low not written");
	gain_read_a: assert property (@(posedge clock) disable iff (srst) // RULE11
		rd_stb && sel_gcal_hi |=> rdata == $past(gcal_hi_reg))
		else $error("gain high read wrong");
	setup_rsvd_a: assert property (@(posedge clock) disable iff (srst) // RULE12
		rd_stb && sel_setup |=> rdata[5:3] == 3'h0)
		else $error("setup reserved bits not zero");
	coeff_off_a: assert property (@(posedge clock) disable iff (srst) // RULE13
		coeff_reg == 4'h0 |=> !ch1_filter_active)
		else $error("filter active with global off");
	setup_reset_a: assert property (@(posedge clock) // RULE14
		srst |=> setup_reg == 16'h0000)
		else $error("setup reset wrong");
	rsvd_write_a: assert property (@(posedge clock) disable iff (srst) // RULE15
		wr_stb && sel_setup |=> setup_reg[5:3] == 3'h0)
		else $error("reserved setup bits took a write");

	// Reset values land on the reset edge itself.
	phase_reset_a: assert property (@(posedge clock) // RULE1
		srst |=> ch1_phase_delay == 10'h000)
		else $error("phase delay reset wrong");
	filter_reset_a: assert property (@(posedge clock) // RULE2
		srst |=> !ch1_filter_active)
		else $error("filter active after reset");
	select_reset_a: assert property (@(posedge clock) // RULE3
		srst |=> ch1_input_select == 2'(ccr_pkg::CCR_SEL_PINS))
		else $error("input selector reset wrong");
	route_reset_a: assert property (@(posedge clock) // RULE3
		srst |=> {ch1_route_pins, ch1_route_short, ch1_route_test_pos, ch1_route_test_neg} == 4'h8)
		else $error("routing reset wrong");
	offset_reset_a: assert property (@(posedge clock) // RULE11
		srst |=> ch1_offset_word == 24'h000000)
		else $error("offset reset wrong");
	rdata_reset_a: assert property (@(posedge clock) // RULE11
		srst |=> rdata == 16'h0000)
		else $error("read data not cleared by reset");
	coeff_reset_a: assert property (@(posedge clock) // RULE13
		srst |=> ch1_filter_coeff == ccr_pkg::DC_COEFF_RESET)
		else $error("coefficient reset wrong");

	// Register writes and read-back.
	phase_read_a: assert property (@(posedge clock) disable iff (srst) // RULE1
		rd_stb && sel_setup |=>
		rdata[ccr_pkg::PHASE_MSB:ccr_pkg::PHASE_LSB] == $past(ch1_phase_delay))
		else $error("phase delay read wrong");
	filter_write_a: assert property (@(posedge clock) disable iff (srst) // RULE2
		wr_stb && sel_setup |=>
		setup_reg[ccr_pkg::FILT_OFF_BIT] == $past(wdata[ccr_pkg::FILT_OFF_BIT]))
		else $error("filter override not written");
	select_write_a: assert property (@(posedge clock) disable iff (srst) // RULE3
		wr_stb && sel_setup |=> ch1_input_select == $past(wdata[ccr_pkg::SEL_MSB:0]))
		else $error("input selector not written");
	setup_read_a: assert property (@(posedge clock) disable iff (srst) // RULE14
		rd_stb && sel_setup |=> rdata == $past(setup_reg))
		else $error("setup read wrong");
	ocal_hi_read_a: assert property (@(posedge clock) disable iff (srst) // RULE6
		rd_stb && sel_ocal_hi |=> rdata == $past(ch1_offset_word[23:8]))
		else $error("offset high read wrong");
	ocal_lo_read_a: assert property (@(posedge clock) disable iff (srst) // RULE7
		rd_stb && sel_ocal_lo |=> rdata[15:8] == $past(ch1_offset_word[7:0]))
		else $error("offset low read wrong");
	gcal_hi_write_a: assert property (@(posedge clock) disable iff (srst) // RULE9
		wr_stb && sel_gcal_hi |=> ch1_gain_word[23:8] == $past(wdata))
		else $error("gain high not written");
	gcal_lo_read_a: assert property (@(posedge clock) disable iff (srst) // RULE10
		rd_stb && sel_gcal_lo |=> rdata[15:8] == $past(ch1_gain_word[7:0]))
		else $error("gain low read wrong");
	coeff_write_a: assert property (@(posedge clock) disable iff (srst) // RULE13
		wr_stb && sel_coeff |=> ch1_filter_coeff == $past(wdata[3:0]))
		else $error("coefficient not written");
	coeff_read_a: assert property (@(posedge clock) disable iff (srst) // RULE13
		rd_stb && sel_coeff |=> rdata == {12'h000, $past(ch1_filter_coeff)})
		else $error("coefficient read wrong");
	unmapped_read_a: assert property (@(posedge clock) disable iff (srst) // RULE11
		rd_stb && !sel_any |=> rdata == ccr_pkg::READ_UNMAPPED)
		else $error("unmapped read not zero");
	rdata_idle_a: assert property (@(posedge clock) disable iff (srst) // RULE11
		!srst && !rd_stb |=> rdata == 16'h0000)
		else $error("read data stands past its cycle");

	// A reset edge legally moves every register, so the hold checks test srst themselves.
	unmapped_write_a: assert property (@(posedge clock) disable iff (srst) // RULE11
		!srst && wr_stb && !sel_any |=>
		$stable(setup_reg) && $stable(ch1_offset_word) && $stable(ch1_gain_word))
		else $error("unmapped write changed a register");
	ocal_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE6
		!srst && !(wr_stb && sel_ocal_hi) |=> $stable(ch1_offset_word[23:8]))
		else $error("offset high changed without a write");
	ocal_lo_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE7
		!srst && !(wr_stb && sel_ocal_lo) |=> $stable(ch1_offset_word[7:0]))
		else $error("offset low changed without a write");
	gcal_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE9
		!srst && !(wr_stb && sel_gcal_hi) |=> $stable(ch1_gain_word[23:8]))
		else $error("gain high changed without a write");
	gcal_lo_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE10
		!srst && !(wr_stb && sel_gcal_lo) |=> $stable(ch1_gain_word[7:0]))
		else $error("gain low changed without a write");
	setup_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE14
		!srst && !(wr_stb && sel_setup) |=> $stable(setup_reg))
		else $error("setup changed without a write");
	setup_rsvd_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE12
		setup_reg[5:3] == 3'h0)
		else $error("reserved setup bits not zero");

	// The route outputs and ch1_filter_active follow their register one cycle later.
	filter_on_a: assert property (@(posedge clock) disable iff (srst) // RULE13
		!srst && !setup_reg[ccr_pkg::FILT_OFF_BIT] && coeff_reg != ccr_pkg::DC_COEFF_OFF |=>
		ch1_filter_active)
		else $error("filter not active when enabled");
	route_onehot_a: assert property (@(posedge clock) disable iff (srst) // RULE5
		$onehot({ch1_route_pins, ch1_route_short, ch1_route_test_pos, ch1_route_test_neg}))
		else $error("routing not one-hot");
	short_only_a: assert property (@(posedge clock) disable iff (srst) // RULE4
		!srst && setup_reg[ccr_pkg::SEL_MSB:0] == 2'(ccr_pkg::CCR_SEL_SHORT) |=>
		!ch1_route_test_pos && !ch1_route_test_neg)
		else $error("test signal fed while shorted");
	test_pos_a: assert property (@(posedge clock) disable iff (srst) // RULE5
		!srst && setup_reg[ccr_pkg::SEL_MSB:0] == 2'(ccr_pkg::CCR_SEL_TEST_POS) |=>
		ch1_route_test_pos && !ch1_route_test_neg)
		else $error("positive test signal not fed");
	test_neg_a: assert property (@(posedge clock) disable iff (srst) // RULE5
		!srst && setup_reg[ccr_pkg::SEL_MSB:0] == 2'(ccr_pkg::CCR_SEL_TEST_NEG) |=>
		ch1_route_test_neg && !ch1_route_test_pos)
		else $error("negative test signal not fed");
endmodule
`default_nettype wire

// ==== bench/ccr_tb.sv ====
// Self-checking testbench for the channel one configuration and calibration bank.
// Assumes ccr_pkg and ccr_regs are compiled first; the bench is the register master.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [5:0] addr = 6'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [15:0] rdata;
	logic [9:0] ch1_phase_delay;
	logic ch1_filter_active;
	logic [3:0] ch1_filter_coeff;
	logic [1:0] ch1_input_select;
	logic ch1_route_pins, ch1_route_short, ch1_route_test_pos, ch1_route_test_neg;
	logic [23:0] ch1_offset_word;
	logic [23:0] ch1_gain_word;
	int error_cnt = 0;
	int checked = 0;
	always #25 clock = ~clock;
	ccr_regs ccr_regs_inst (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ch1_phase_delay(ch1_phase_delay),
		.ch1_filter_active(ch1_filter_active), .ch1_filter_coeff(ch1_filter_coeff),
		.ch1_input_select(ch1_input_select), .ch1_route_pins(ch1_route_pins),
		.ch1_route_short(ch1_route_short), .ch1_route_test_pos(ch1_route_test_pos),
		.ch1_route_test_neg(ch1_route_test_neg), .ch1_offset_word(ch1_offset_word),
		.ch1_gain_word(ch1_gain_word));
	// ==========================================================
	// Bus tasks and comparison
	// ==========================================================
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	// The read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic settle();
		@(posedge clock);
		#1;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Watchdog
	// ==========================================================
	initial begin
		repeat (3000) @(posedge clock);
		error_cnt++;
		print_verdict();
	end
	// ==========================================================
	// Test sequence
	// ==========================================================
	initial begin
		logic [15:0] d;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		rd(6'h0E, d); check(24'(d), 24'h000000);
		rd(6'h0F, d); check(24'(d), 24'h000000);
		rd(6'h10, d); check(24'(d), 24'h000000);
		rd(6'h11, d); check(24'(d), 24'h008000);
		rd(6'h12, d); check(24'(d), 24'h000000);
		check(ch1_gain_word, 24'h800000);
		check(24'(ch1_route_pins), 24'h000001);
		wr(6'h0E, 16'hFFFF);
		rd(6'h0E, d); check(24'(d), 24'h00FFC7);
		check(24'(ch1_phase_delay), 24'h0003FF);
		wr(6'h0E, 16'h0038);
		rd(6'h0E, d); check(24'(d), 24'h000000);
		for (int i = 0; i < 4; i++) begin
			wr(6'h0E, 16'(i));
			settle();
			check(24'(ch1_input_select), 24'(i));
			check(24'({ch1_route_pins, ch1_route_short, ch1_route_test_pos,
				ch1_route_test_neg}), 24'(4'h8 >> i));
		end
		wr(6'h13, 16'h0001);
		wr(6'h0E, 16'h0000);
		settle();
		check(24'({ch1_filter_coeff, ch1_filter_active}), 24'h000003);
		rd(6'h13, d); check(24'(d), 24'h000001);
		wr(6'h0E, 16'h0004);
		settle();
		check(24'(ch1_filter_active), 24'h000000);
		wr(6'h0E, 16'h0000);
		wr(6'h13, 16'h0000);
		settle();
		check(24'(ch1_filter_active), 24'h000000);
		wr(6'h0F, 16'h1234);
		wr(6'h10, 16'hABCD);
		rd(6'h10, d); check(24'(d), 24'h00AB00);
		check(ch1_offset_word, 24'h1234AB);
		wr(6'h11, 16'h5A5A);
		wr(6'h12, 16'hFFFF);
		rd(6'h12, d); check(24'(d), 24'h00FF00);
		check(ch1_gain_word, 24'h5A5AFF);
		rd(6'h11, d); check(24'(d), 24'h005A5A);
		wr(6'h3F, 16'hFFFF);
		rd(6'h3F, d); check(24'(d), 24'h000000);
		check(ch1_offset_word, 24'h1234AB);
		@(posedge clock);
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		rd(6'h11, d); check(24'(d), 24'h008000);
		check(ch1_offset_word, 24'h000000);
		print_verdict();
	end
endmodule
`default_nettype wire
